// ---- pbmux_core.sv ----
// Port B pin function mux: Avalon-MM registers, function selection and test port takeover
//
// Functional notes
// - Field 13:12 selects pin 38, code 00 (reset) is general-purpose I/O and all other codes are reserved.
// - While the test port select input is 1, pins 35 to 38 carry test data in, mode select, data out and clock.
// - Pin 38 can also feed an external oscillator clock to the core.
// - Field 11:10 selects pin 37, code 00 (reset) is general-purpose I/O and all other codes are reserved.
// - Field 9:8 selects pin 36, code 00 (reset) is general-purpose I/O and all other codes are reserved.
// - Field 7:6 selects pin 35, code 00 (reset) is general-purpose I/O and all other codes are reserved.
// - Field 5:4 selects pin 34, 00 general-purpose I/O, 01 comparator two output, 10 and 11 reserved.
// - Field 3:2 selects pin 33, 00 I/O, 01 I2C clock, 10 PWM sync out, 11 conversion start B out.
// - Field 1:0 selects pin 32, 00 I/O, 01 I2C data, 10 PWM sync in, 11 conversion start A out.
// - In I2C mode pins 32 and 33 are open drain: they only pull low and are always sensed.
`timescale 1ns/1ps
`include "pbmux_regs.svh"
module pbmux_core
    import pbmux_pkg::*;
#(
    parameter int PINS = 7
)
(
    input  wire logic              clk,
    input  wire logic              nrst,
    // Avalon-MM slave
    input  wire logic [3:0]        avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    input  wire logic [3:0]        avs_byteenable,
    output logic [31:0]            avs_readdata,
    output logic                   avs_waitrequest,
    // Pads of pins 32 to 38
    input  wire logic [PINS-1:0]   pad_in,
    output logic [PINS-1:0]        pad_out,
    output logic [PINS-1:0]        pad_oe_n,
    // General-purpose I/O side
    input  wire logic [PINS-1:0]   gpio_out,
    input  wire logic [PINS-1:0]   gpio_dir,
    output logic [PINS-1:0]        gpio_in,
    // Peripherals
    input  wire logic              comparator_two_output,
    input  wire logic              i2c_clock_line_pull_low,
    output logic                   i2c_clock_line_in,
    input  wire logic              i2c_data_line_pull_low,
    output logic                   i2c_data_line_in,
    input  wire logic              pwm_sync_pulse_out,
    output logic                   pwm_sync_pulse_in,
    input  wire logic              conversion_start_a_out,
    input  wire logic              conversion_start_b_out,
    output logic                   external_oscillator_clock_in,
    // Test port
    input  wire logic              test_port_select,
    input  wire logic              test_data_out,
    input  wire logic              test_data_out_en,
    output logic                   test_data_in,
    output logic                   test_mode_select,
    output logic                   test_clock_in,
    // Analog pin blocking, one per analog field, high blocks the digital path
    output logic [5:0]             analog_pin_blocked
);

    // Configuration registers
    logic [31:0] port_b_function_select_r;
    logic [31:0] analog_pin_function_select_r;
    logic [31:0] avs_readdata_r;
    logic        ack_r;

    // Per-pin signals
    pbmux_func_t       func     [PINS];
    logic [PINS-1:0]   pin_in_q;
    logic [3:0]        cand_out [PINS];
    logic [3:0]        cand_oe  [PINS];
    logic [PINS-1:0]   test_pin;
    logic [PINS-1:0]   test_out;
    logic [PINS-1:0]   test_oe;

    // Bus decode: one wait cycle, then the access completes
    wire bus_req      = avs_read | avs_write;
    wire sel_func     = (avs_address[3:2] == 2'(`PBMUX_FUNC_SEL_OFS >> 2));
    wire sel_analog   = (avs_address[3:2] == 2'(`PBMUX_ANALOG_SEL_OFS >> 2));
    wire sel_status   = (avs_address[3:2] == 2'(`PBMUX_STATUS_OFS >> 2));
    wire wr_commit    = avs_write & ack_r;
    wire [31:0] be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                           {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    wire [31:0] func_wmask   = be_mask & `PBMUX_FUNC_SEL_MASK;
    wire [31:0] analog_wmask = be_mask & `PBMUX_ANALOG_SEL_MASK;

    // Status word: test takeover and sampled pin levels
    wire [31:0] status_word = (32'({PINS{1'b0}} | pin_in_q) << `PBMUX_STAT_PIN_LSB)
                            | (32'(test_port_select) << `PBMUX_STAT_TEST_BIT);

    // Read data selection; unmapped addresses read zero
    wire [31:0] rd_word = sel_func   ? port_b_function_select_r :
                          sel_analog ? analog_pin_function_select_r :
                          sel_status ? status_word : 32'h0000_0000;

    assign avs_waitrequest = bus_req & ~ack_r;
    assign avs_readdata    = avs_readdata_r;

    // Completion flag, high for the last cycle of each access
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            ack_r <= 1'b0;
        else
            ack_r <= bus_req & ~ack_r;
    end

    // Read data register
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            avs_readdata_r <= 32'h0000_0000;
        else if (avs_read & ~ack_r)
            avs_readdata_r <= rd_word;
    end

    // Function register, reserved upper bits held at zero
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            port_b_function_select_r <= `PBMUX_FUNC_SEL_RESET;
        else if (wr_commit & sel_func)
            port_b_function_select_r <= (port_b_function_select_r & ~func_wmask)
                                      | (avs_writedata & func_wmask);
    end

    // Analog register, reserved bits held at zero
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            analog_pin_function_select_r <= `PBMUX_ANALOG_SEL_RESET;
        else if (wr_commit & sel_analog)
            analog_pin_function_select_r <= (analog_pin_function_select_r & ~analog_wmask)
                                          | (avs_writedata & analog_wmask);
    end

    // Analog block bits: upper bit of each field disables the digital path
    assign analog_pin_blocked[0] = analog_pin_function_select_r[5];
    assign analog_pin_blocked[1] = analog_pin_function_select_r[9];
    assign analog_pin_blocked[2] = analog_pin_function_select_r[13];
    assign analog_pin_blocked[3] = analog_pin_function_select_r[21];
    assign analog_pin_blocked[4] = analog_pin_function_select_r[25];
    assign analog_pin_blocked[5] = analog_pin_function_select_r[29];

    // Pin 32 candidates: I/O, I2C data, sync in, conversion start A
    assign cand_out[`PBMUX_PIN_32] = {conversion_start_a_out, 1'b0, 1'b0, gpio_out[`PBMUX_PIN_32]};
    assign cand_oe[`PBMUX_PIN_32]  = {1'b1, 1'b0, i2c_data_line_pull_low, gpio_dir[`PBMUX_PIN_32]};

    // Pin 33 candidates: I/O, I2C clock, sync out, conversion start B
    assign cand_out[`PBMUX_PIN_33] = {conversion_start_b_out, pwm_sync_pulse_out, 1'b0,
                                      gpio_out[`PBMUX_PIN_33]};
    assign cand_oe[`PBMUX_PIN_33]  = {1'b1, 1'b1, i2c_clock_line_pull_low, gpio_dir[`PBMUX_PIN_33]};

    // Pin 34 candidates: I/O, comparator two; reserved codes leave the pad undriven
    assign cand_out[`PBMUX_PIN_34] = {1'b0, 1'b0, comparator_two_output, gpio_out[`PBMUX_PIN_34]};
    assign cand_oe[`PBMUX_PIN_34]  = {1'b0, 1'b0, 1'b1, gpio_dir[`PBMUX_PIN_34]};

    // Pins 35 to 38: only I/O, reserved codes undriven
    assign cand_out[`PBMUX_PIN_35] = {3'h0, gpio_out[`PBMUX_PIN_35]};
    assign cand_oe[`PBMUX_PIN_35]  = {3'h0, gpio_dir[`PBMUX_PIN_35]};
    assign cand_out[`PBMUX_PIN_36] = {3'h0, gpio_out[`PBMUX_PIN_36]};
    assign cand_oe[`PBMUX_PIN_36]  = {3'h0, gpio_dir[`PBMUX_PIN_36]};
    assign cand_out[`PBMUX_PIN_37] = {3'h0, gpio_out[`PBMUX_PIN_37]};
    assign cand_oe[`PBMUX_PIN_37]  = {3'h0, gpio_dir[`PBMUX_PIN_37]};
    assign cand_out[`PBMUX_PIN_38] = {3'h0, gpio_out[`PBMUX_PIN_38]};
    assign cand_oe[`PBMUX_PIN_38]  = {3'h0, gpio_dir[`PBMUX_PIN_38]};

    // Test port takeover of pins 35 to 38; only the data out pin drives
    assign test_pin = PINS'({4{test_port_select}}) << `PBMUX_PIN_35;
    assign test_out = PINS'(test_data_out) << `PBMUX_PIN_37;
    assign test_oe  = PINS'(test_data_out_en) << `PBMUX_PIN_37;

    // Pad driver per pin
    genvar i;
    generate
        for (i = 0; i < PINS; i++)
        begin : g_pin
            pbmux_pin_if pin_bus ();

            assign func[i]          = pbmux_func_t'(port_b_function_select_r[2*i +: `PBMUX_FUNC_FIELD_W]);
            assign pin_bus.func     = func[i];
            assign pin_bus.test_en  = test_pin[i];
            assign pin_bus.test_out = test_out[i];
            assign pin_bus.test_oe  = test_oe[i];
            assign pin_bus.cand_out = cand_out[i];
            assign pin_bus.cand_oe  = cand_oe[i];
            assign pin_in_q[i]      = pin_bus.in_q;
            assign pad_out[i]       = pin_bus.out_q;
            assign pad_oe_n[i]      = pin_bus.oe_n_q;

            pbmux_pad u_pad
            (
                .clk    (clk),
                .nrst   (nrst),
                .pad_in (pad_in[i]),
                .pin    (pin_bus.pad)
            );
        end
    endgenerate

    // Sensed levels back to I/O and peripherals
    assign gpio_in = pin_in_q;

    // I2C lines are sensed while selected, idle high otherwise
    assign i2c_data_line_in  = (func[`PBMUX_PIN_32] == PBMUX_FUNC_ALT1) ? pin_in_q[`PBMUX_PIN_32] : 1'b1;
    assign i2c_clock_line_in = (func[`PBMUX_PIN_33] == PBMUX_FUNC_ALT1) ? pin_in_q[`PBMUX_PIN_33] : 1'b1;

    // Sync input only while pin 32 is in sync-in mode
    assign pwm_sync_pulse_in = (func[`PBMUX_PIN_32] == PBMUX_FUNC_ALT2) & pin_in_q[`PBMUX_PIN_32];

    // Test inputs only while the test port owns the pins
    assign test_data_in     = test_port_select & pin_in_q[`PBMUX_PIN_35];
    assign test_mode_select = test_port_select & pin_in_q[`PBMUX_PIN_36];
    assign test_clock_in    = test_port_select & pin_in_q[`PBMUX_PIN_38];

    // Oscillator clock path from pin 38 is always open
    assign external_oscillator_clock_in = pin_in_q[`PBMUX_PIN_38];

endmodule // pbmux_core

// ---- pbmux_regs.svh ----
// Register offsets, field positions, reset values and masks of the port B pin function mux
`ifndef PBMUX_REGS_SVH
`define PBMUX_REGS_SVH

// Register byte offsets
`define PBMUX_FUNC_SEL_OFS      4'h0
`define PBMUX_ANALOG_SEL_OFS    4'h4
`define PBMUX_STATUS_OFS        4'h8

// Port B function select register
`define PBMUX_FUNC_SEL_RESET    32'h0000_0000
`define PBMUX_FUNC_SEL_MASK     32'h0000_3FFF
`define PBMUX_FUNC_FIELD_W      2

// Analog pin function select register
`define PBMUX_ANALOG_SEL_RESET  32'h2220_2220
`define PBMUX_ANALOG_SEL_MASK   32'h3330_3330

// Status register fields
`define PBMUX_STAT_TEST_BIT     0
`define PBMUX_STAT_PIN_LSB      8

// Pin indices inside port B (pin 32 is index 0)
`define PBMUX_PIN_32            0
`define PBMUX_PIN_33            1
`define PBMUX_PIN_34            2
`define PBMUX_PIN_35            3
`define PBMUX_PIN_36            4
`define PBMUX_PIN_37            5
`define PBMUX_PIN_38            6

`endif

// ---- pbmux_pkg.sv ----
// Types shared by the port B pin function mux
package pbmux_pkg;

    // Two-bit function code of one pin
    typedef enum logic [1:0]
    {
        PBMUX_FUNC_GPIO = 2'h0,
        PBMUX_FUNC_ALT1 = 2'h1,
        PBMUX_FUNC_ALT2 = 2'h2,
        PBMUX_FUNC_ALT3 = 2'h3
    } pbmux_func_t;

endpackage

// ---- pbmux_pin_if.sv ----
// Per-pin connection between the mux core and one pad driver
`timescale 1ns/1ps
interface pbmux_pin_if;
    import pbmux_pkg::*;

    pbmux_func_t func;      // Selected function code
    logic        test_en;   // Test port owns the pin
    logic        test_out;  // Test port output value
    logic        test_oe;   // Test port drives the pin
    logic [3:0]  cand_out;  // Output value per function code
    logic [3:0]  cand_oe;   // Drive request per function code
    logic        in_q;      // Registered pin level
    logic        out_q;     // Registered pad output value
    logic        oe_n_q;    // Registered pad output enable, low drives

    modport core (output func, output test_en, output test_out, output test_oe,
                  output cand_out, output cand_oe, input in_q, input out_q, input oe_n_q);
    modport pad  (input func, input test_en, input test_out, input test_oe,
                  input cand_out, input cand_oe, output in_q, output out_q, output oe_n_q);
endinterface

// ---- pbmux_pad.sv ----
// Pad driver of one port B pin: selects drive by function and registers pad signals
`timescale 1ns/1ps
module pbmux_pad
    import pbmux_pkg::*;
(
    input  wire logic   clk,
    input  wire logic   nrst,
    input  wire logic   pad_in,
    pbmux_pin_if.pad    pin
);

    // Selected drive: test port wins over the function field
    wire drive_val = pin.test_en ? pin.test_out : pin.cand_out[pin.func];
    wire drive_en  = pin.test_en ? pin.test_oe  : pin.cand_oe[pin.func];

    // Pad output, enable and input sample registers; reset leaves the pad undriven
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pin.out_q  <= 1'b0;
            pin.oe_n_q <= 1'b1;
            pin.in_q   <= 1'b0;
        end
        else
        begin
            pin.out_q  <= drive_val;
            pin.oe_n_q <= ~drive_en;
            pin.in_q   <= pad_in;
        end
    end

endmodule // pbmux_pad

// ---- pbmux_core_sva.sv ----
// Concurrent checks of the port B pin function mux, bound to its top module
`timescale 1ns/1ps
module pbmux_core_sva
    import pbmux_pkg::*;
#(
    parameter int PINS = 7
)
(
    input wire logic            clk,
    input wire logic            nrst,
    input wire logic [3:0]      avs_address,
    input wire logic            avs_read,
    input wire logic            avs_write,
    input wire logic [31:0]     avs_writedata,
    input wire logic [3:0]      avs_byteenable,
    input wire logic [31:0]     avs_readdata,
    input wire logic            avs_waitrequest,
    input wire logic [PINS-1:0] pad_in,
    input wire logic [PINS-1:0] pad_out,
    input wire logic [PINS-1:0] pad_oe_n,
    input wire logic [PINS-1:0] gpio_dir,
    input wire logic            comparator_two_output,
    input wire logic            i2c_data_line_pull_low,
    input wire logic            pwm_sync_pulse_out,
    input wire logic            conversion_start_a_out,
    input wire logic            external_oscillator_clock_in,
    input wire logic            test_port_select,
    input wire logic            test_data_out,
    input wire logic            test_data_out_en
);
    logic [13:0] shadow_r;
    logic [13:0] shadow_nxt;
    logic        func_wr;

    // Mirror of the function fields, so pin checks know the selected codes
    assign func_wr    = avs_write && !avs_waitrequest && avs_address[3:2] == 2'h0;
    assign shadow_nxt = {avs_byteenable[1] ? avs_writedata[13:8] : shadow_r[13:8],
                         avs_byteenable[0] ? avs_writedata[7:0] : shadow_r[7:0]};
    always_ff @(posedge clk or negedge nrst)
        if (!nrst)
            shadow_r <= 14'h0;
        else if (func_wr)
            shadow_r <= shadow_nxt;

    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    // Readback, pin drive per code and test port takeover
    property p_readback; avs_read && !avs_waitrequest && avs_address[3:2] == 2'h0 |-> avs_readdata == {18'h0, shadow_r}; endproperty
    a_readback: assert property (p_readback) else $error("function readback wrong");
    property p_gpio; shadow_r[13:6] == 8'h0 && !test_port_select |=> pad_oe_n[6:3] == ~$past(gpio_dir[6:3]); endproperty
    a_gpio: assert property (p_gpio) else $error("pins 35 to 38 not in I/O mode");
    property p_test_rel; test_port_select [*2] |-> pad_oe_n[6] && pad_oe_n[4] && pad_oe_n[3]; endproperty
    a_test_rel: assert property (p_test_rel) else $error("test input pin driven");
    property p_test_drv; test_port_select && test_data_out_en |=> !pad_oe_n[5] && pad_out[5] == $past(test_data_out); endproperty
    a_test_drv: assert property (p_test_drv) else $error("test data out not on pin 37");
    property p_osc; nrst |=> external_oscillator_clock_in == $past(pad_in[6]); endproperty
    a_osc: assert property (p_osc) else $error("oscillator input wrong");
    property p_comp; shadow_r[5:4] == 2'h1 |=> !pad_oe_n[2] && pad_out[2] == $past(comparator_two_output); endproperty
    a_comp: assert property (p_comp) else $error("comparator not on pin 34");
    property p_sync; shadow_r[3:2] == 2'h2 |=> !pad_oe_n[1] && pad_out[1] == $past(pwm_sync_pulse_out); endproperty
    a_sync: assert property (p_sync) else $error("sync out not on pin 33");
    property p_conv; shadow_r[1:0] == 2'h3 |=> !pad_oe_n[0] && pad_out[0] == $past(conversion_start_a_out); endproperty
    a_conv: assert property (p_conv) else $error("conversion start A not on pin 32");
    property p_i2c; shadow_r[1:0] == 2'h1 |=> !pad_out[0] && pad_oe_n[0] == !$past(i2c_data_line_pull_low); endproperty
    a_i2c: assert property (p_i2c) else $error("I2C data pin not open drain");
endmodule // pbmux_core_sva

bind pbmux_core pbmux_core_sva #(.PINS(PINS)) pbmux_core_sva_inst (.*);

// ---- pbmux_pins.sv ----
// Pin-side model of the port B pads: far-side drivers, pull-ups, floating lines
`timescale 1ns/1ps
module pbmux_pins
(
    input  wire logic       clk,
    input  wire logic [6:0] pad_out,
    input  wire logic [6:0] pad_oe_n,
    input  wire logic [6:0] ext_en,
    input  wire logic [6:0] ext_val,
    output logic      [6:0] pad_in
);
    logic float_r = 1'h0;

    // A released plain line shows a level that flips every cycle
    always_ff @(posedge clk)
        float_r <= ~float_r;

    // Device drive wins, then the far side; the I2C pins have pull-ups
    always_comb
        for (int i = 0; i < 7; i++)
            pad_in[i] = !pad_oe_n[i] ? pad_out[i] : ext_en[i] ? ext_val[i] : (i < 2 ? 1'h1 : float_r);
endmodule // pbmux_pins

// ---- pbmux_core_tb.sv ----
// Self-checking testbench of the port B pin function mux
`timescale 1ns/1ps
`include "pbmux_regs.svh"
module pbmux_core_tb import pbmux_pkg::*; ;
    logic        clk, nrst, avs_read, avs_write, avs_waitrequest, test_port_select;
    logic [3:0]  avs_address, avs_byteenable;
    logic [31:0] avs_readdata, avs_writedata, seed, rd;
    logic [6:0]  pad_in, pad_out, pad_oe_n, gpio_out, gpio_dir, gpio_in, ext_en, ext_val, m;
    logic        comparator_two_output, i2c_clock_line_pull_low, i2c_clock_line_in, i2c_data_line_pull_low;
    logic        i2c_data_line_in, pwm_sync_pulse_out, pwm_sync_pulse_in, conversion_start_a_out;
    logic        conversion_start_b_out, external_oscillator_clock_in, test_data_out, test_data_out_en;
    logic        test_data_in, test_mode_select, test_clock_in;
    logic [5:0]  analog_pin_blocked;
    logic [1:0]  c0, c1, c2;
    int          fail_count, n_checks;

    pbmux_core pbmux_core_inst (.*);
    pbmux_pins pbmux_pins_inst (.*);

    always #5 clk = ~clk;

    // Random source and expected pad drive {oe_n, out} per pin and code
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [1:0] exp_pin(int p, logic [1:0] c);
        if (p > 2 || c == 2'h0)
            return {~gpio_dir[p], gpio_out[p]};
        case ({p[1:0], c})
            4'h1: return {~i2c_data_line_pull_low, 1'h0};
            4'h2: return 2'h2;
            4'h3: return {1'h0, conversion_start_a_out};
            4'h5: return {~i2c_clock_line_pull_low, 1'h0};
            4'h6: return {1'h0, pwm_sync_pulse_out};
            4'h7: return {1'h0, conversion_start_b_out};
            default: return {1'h0, comparator_two_output};
        endcase
    endfunction

    task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
        n_checks++;
        if (s !== e)
        begin
            $display("ERROR %s expected %h seen %h", nm, e, s);
            fail_count++;
        end
    endtask
    // One Avalon access, held until waitrequest is seen low
    task automatic bus(logic wr, logic [3:0] a, logic [31:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        @(posedge clk);
        while (avs_waitrequest !== 1'h0 && n < 20)
        begin
            @(posedge clk);
            n++;
        end
        chk("waitrequest", 32'h0, {31'h0, avs_waitrequest});
        rd = avs_readdata;
        avs_write <= 1'h0;
        avs_read <= 1'h0;
        @(posedge clk);
    endtask
    task automatic stir();
        rd = rnd();
        {comparator_two_output, i2c_clock_line_pull_low, i2c_data_line_pull_low, pwm_sync_pulse_out,
         conversion_start_a_out, conversion_start_b_out, test_data_out, test_data_out_en} <= rd[7:0];
        {gpio_out, gpio_dir, ext_val} <= rd[28:8];
        ext_en <= {rd[31:29], rd[3:0]} | 7'h40;
    endtask
    task automatic tally_and_finish();
        if (fail_count == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial
    begin
        #50000;
        fail_count++;
        tally_and_finish();
    end

    // Reset, register map, random function codes, then test port takeover
    initial
    begin
        seed = 32'h04EB;
        {clk, nrst, avs_read, avs_write, test_port_select} = 5'h0;
        {avs_address, avs_writedata, avs_byteenable} = 40'hF;
        stir();
        repeat (2) @(posedge clk);
        nrst <= 1'h1;
        @(posedge clk);
        bus(1'h0, `PBMUX_FUNC_SEL_OFS, 32'h0);
        chk("func_reset", `PBMUX_FUNC_SEL_RESET, rd);
        bus(1'h0, `PBMUX_ANALOG_SEL_OFS, 32'h0);
        chk("analog_reset", `PBMUX_ANALOG_SEL_RESET, rd);
        bus(1'h1, `PBMUX_ANALOG_SEL_OFS, 32'hFFFFFFFF);
        bus(1'h0, `PBMUX_ANALOG_SEL_OFS, 32'h0);
        chk("analog_mask", `PBMUX_ANALOG_SEL_MASK, rd);
        chk("blocked", 32'h3F, {26'h0, analog_pin_blocked});
        bus(1'h1, 4'hC, 32'hFFFFFFFF);
        bus(1'h0, 4'hC, 32'h0);
        chk("unmapped", 32'h0, rd);
        repeat (40)
        begin
            stir();
            rd = rnd();
            c0 = rd[1:0];
            c1 = rd[3:2];
            c2 = {1'h0, rd[4]};
            bus(1'h1, `PBMUX_FUNC_SEL_OFS, {rd[31:14], 8'h00, c2, c1, c0});
            bus(1'h0, `PBMUX_FUNC_SEL_OFS, 32'h0);
            chk("func_sel", {26'h0, c2, c1, c0}, rd);
            for (int p = 0; p < 7; p++)
            begin
                m[1:0] = exp_pin(p, p == 0 ? c0 : p == 1 ? c1 : c2);
                chk("pad_oe_n", m[1], pad_oe_n[p]);
                if (!m[1]) chk("pad_out", m[0], pad_out[p]);
            end
            m = ~pad_oe_n | ext_en | 7'h03;
            chk("gpio_in", pad_in & m, gpio_in & m);
            chk("i2c_data_in", c0 == 2'h1 ? pad_in[0] : 1'h1, i2c_data_line_in);
            chk("sync_in", c0 == 2'h2 ? pad_in[0] : 1'h0, pwm_sync_pulse_in);
            chk("i2c_clock_in", c1 == 2'h1 ? pad_in[1] : 1'h1, i2c_clock_line_in);
            chk("osc_in", pad_in[6], external_oscillator_clock_in);
        end
        for (int k = 0; k < 2; k++)
        begin
            stir();
            @(posedge clk);
            test_port_select <= 1'h1;
            test_data_out_en <= k[0];
            ext_en <= 7'h7F;
            repeat (3) @(posedge clk);
            chk("test_oe_n", {1'h1, ~k[0], 2'h3}, pad_oe_n[6:3]);
            if (k == 1) chk("test_out", test_data_out, pad_out[5]);
            chk("test_in", {pad_in[6], pad_in[4:3]}, {test_clock_in, test_mode_select, test_data_in});
            bus(1'h0, `PBMUX_STATUS_OFS, 32'h0);
            chk("status", {17'h0, pad_in, 7'h0, test_port_select}, rd);
        end
        tally_and_finish();
    end
endmodule // pbmux_core_tb
